/* File: hdl/frr_top.sv */
// fault-return rerun unit: completes faulted bus cycles when the handler returns
// assumes the core loads the frame image over AXI4-Lite, then sets start
//
// Functional notes
// - address-error frames are never recovered by rerun; they are refused (here only when a stage rerun bit or the data-fault flag is set).
// - a set data-fault flag at return reruns the faulted data cycle.
// - stage with fault and rerun bits set gets its prefetch rerun; may refault.
// - stage with rerun only is prefetched only when the core needs it.
// - a refault deallocates the old frame, builds a new one, starts exception.
// - locked operation with data fault re-executes the whole locked instruction.
// - cycles with read-modify-cycle indicator are classed as writes for protection.
// - six frame formats are known, each with its own length.
// - frame words move as long words when the stack is long aligned (here the status transfer count goes by pfaddr_r alignment instead).
// - frame words may move in any order.
// - setting a stage fault bit also sets its rerun bit.
// - prefetch rerun uses program space of the saved privilege level.
// - clear data-fault flag means saved data is taken as valid, no cycle.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
module frr_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write channels
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// ordinary core cycles passing through
	input wire frr_pkg::frr_cyc_t core_cyc,
	input wire logic core_valid,
	output logic core_done,
	output logic core_err,
	// processor bus
	output frr_pkg::frr_cyc_t bus_cyc,
	output logic bus_valid,
	input wire logic bus_ack,
	input wire logic bus_err,
	input wire logic [31:0] bus_rdata,
	// core sequencing
	output logic locked_restart,
	output logic frame_dealloc,
	output logic frame_build,
	output logic exc_start,
	output frr_pkg::frr_exc_t exc_kind,
	// interrupt
	output logic irq
);
	import frr_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		FRR_ST_IDLE = 4'h0,
		FRR_ST_DATA = 4'h1,
		FRR_ST_PF_C = 4'h2,
		FRR_ST_PF_B = 4'h3,
		FRR_ST_LOCK = 4'h4,
		FRR_ST_DEALLOC = 4'h5,
		FRR_ST_BUILD = 4'h6,
		FRR_ST_EXC = 4'h7,
		FRR_ST_DONE = 4'h8
	} frr_st_t;

	frr_st_t st_r, st_nxt;
	logic [31:0] ctrl_r, faddr_r, frame_r, pfaddr_r, dib_r, stage_r;
	logic [15:0] ssw_r;
	logic [FRR_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
	frr_cyc_t cyc_r;
	logic req_r;
	logic aw_held_r, w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_fire, start_pulse;
	logic [31:0] wr_merge;
	logic pr_write, pr_viol;
	logic rerun_busy, cyc_ok, cyc_bad;
	frr_cyc_t mux_cyc;
	logic mux_valid;
	frr_exc_t exc_kind_nxt;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// pick the next rerun step; data first, then stage C, then stage B
	function automatic frr_st_t frr_next(input logic [15:0] saved_fault_status_word, input logic [31:0] ctrl,
			input logic [1:0] after);
		logic do_c, do_b;
		do_c = saved_fault_status_word[FRR_SSW_STAGE_C_RERUN] & (saved_fault_status_word[FRR_SSW_STAGE_C_FAULT] | ctrl[FRR_CTRL_NEED_C]);
		do_b = saved_fault_status_word[FRR_SSW_STAGE_B_RERUN] & (saved_fault_status_word[FRR_SSW_STAGE_B_FAULT] | ctrl[FRR_CTRL_NEED_B]);
		if (after == 2'h0 && saved_fault_status_word[FRR_SSW_DATA_FAULT]) begin
			frr_next = saved_fault_status_word[FRR_SSW_LOCKED] ? FRR_ST_LOCK : FRR_ST_DATA;
		end else if (after <= 2'h1 && do_c) begin
			frr_next = FRR_ST_PF_C;
		end else if (after <= 2'h2 && do_b) begin
			frr_next = FRR_ST_PF_B;
		end else begin
			frr_next = FRR_ST_DONE;
		end
	endfunction

	// length of a frame in 16-bit words
	function automatic logic [5:0] frr_words(input logic [3:0] fmt);
		unique case (fmt)
			FRR_FMT_NORMAL4, FRR_FMT_THROW4: frr_words = FRR_WORDS_4;
			FRR_FMT_NORMAL6: frr_words = FRR_WORDS_6;
			FRR_FMT_COPROC: frr_words = FRR_WORDS_COPROC;
			FRR_FMT_SHORT_BUS: frr_words = FRR_WORDS_SHORT;
			FRR_FMT_LONG_BUS: frr_words = FRR_WORDS_LONG;
			default: frr_words = 6'h00;
		endcase
	endfunction

	// prefetch cycle in the saved privilege level's program space
	function automatic frr_cyc_t frr_pf(input logic [31:0] addr, input logic sup);
		frr_pf.addr = addr;
		frr_pf.space = sup ? FRR_SPACE_SUPER_PROG : FRR_SPACE_USER_PROG;
		frr_pf.size = FRR_SIZE_WORD;
		frr_pf.rd = 1'b1;
		frr_pf.read_modify_cycle_indicator = 1'b0;
	endfunction

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	assign s_awready = ~aw_held_r & ~s_bvalid;
	assign s_wready = ~w_held_r & ~s_bvalid;
	assign wr_fire = aw_held_r & w_held_r & ~s_bvalid;
	assign start_pulse = wr_fire & (aw_addr_r == FRR_OFF_CTRL) & w_data_r[FRR_CTRL_START];

	// address and data may arrive in either order; each is held until both are in
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= FRR_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_wdata;
				w_strb_r <= s_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_addr_r > FRR_OFF_STAGE || aw_addr_r[1:0] != 2'h0) ?
					FRR_RESP_SLVERR : FRR_RESP_OKAY;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// byte-lane merge against the register being written
	always_comb begin
		logic [31:0] old;
		old = 32'h0000_0000;
		unique case (aw_addr_r)
			FRR_OFF_CTRL: old = ctrl_r;
			FRR_OFF_SSW: old = {16'h0000, ssw_r};
			FRR_OFF_FADDR: old = faddr_r;
			FRR_OFF_FRAME: old = frame_r;
			FRR_OFF_PFADDR: old = pfaddr_r;
			FRR_OFF_IRQ_MASK: old = {{(32-FRR_IRQ_W){1'b0}}, irq_mask_r};
			default: old = 32'h0000_0000;
		endcase
		for (int i = 0; i < 4; i++) begin
			wr_merge[i*8 +: 8] = w_strb_r[i] ? w_data_r[i*8 +: 8] : old[i*8 +: 8];
		end
	end

	// ------------------------------------------------------------
	// frame image and setup registers
	// ------------------------------------------------------------
	// start is self-clearing; frame fields are locked while a return is running
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= FRR_CTRL_RST;
			faddr_r <= 32'h0000_0000;
			frame_r <= 32'h0000_0000;
			pfaddr_r <= 32'h0000_0000;
			irq_mask_r <= {FRR_IRQ_W{1'b0}};
		end else if (wr_fire && !rerun_busy) begin
			unique case (aw_addr_r)
				FRR_OFF_CTRL: ctrl_r <= {wr_merge[31:1], 1'b0};
				FRR_OFF_FADDR: faddr_r <= wr_merge;
				FRR_OFF_FRAME: frame_r <= wr_merge;
				FRR_OFF_PFADDR: pfaddr_r <= wr_merge;
				FRR_OFF_IRQ_MASK: irq_mask_r <= wr_merge[FRR_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// saved status word: software loads it, a refault marks the stage again
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ssw_r <= FRR_SSW_RST;
		end else if (wr_fire && !rerun_busy && aw_addr_r == FRR_OFF_SSW) begin
			ssw_r <= wr_merge[15:0];
		end else if (cyc_bad && st_r == FRR_ST_PF_C) begin
			ssw_r[FRR_SSW_STAGE_C_FAULT] <= 1'b1;
			ssw_r[FRR_SSW_STAGE_C_RERUN] <= 1'b1;
		end else if (cyc_bad && st_r == FRR_ST_PF_B) begin
			ssw_r[FRR_SSW_STAGE_B_FAULT] <= 1'b1;
			ssw_r[FRR_SSW_STAGE_B_RERUN] <= 1'b1;
		end else if (cyc_ok && st_r == FRR_ST_DATA) begin
			ssw_r[FRR_SSW_DATA_FAULT] <= 1'b0;
		end else if (cyc_ok && st_r == FRR_ST_PF_C) begin
			ssw_r[FRR_SSW_STAGE_C_RERUN] <= 1'b0;
		end else if (cyc_ok && st_r == FRR_ST_PF_B) begin
			ssw_r[FRR_SSW_STAGE_B_RERUN] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// return sequencer
	// ------------------------------------------------------------
	assign rerun_busy = (st_r != FRR_ST_IDLE);
	assign cyc_ok = req_r & ~pr_viol & bus_ack & ~bus_err;
	assign cyc_bad = req_r & (pr_viol | bus_err);

	always_comb begin
		st_nxt = st_r;
		exc_kind_nxt = exc_kind;
		unique case (st_r)
			FRR_ST_IDLE: begin
				if (start_pulse && frame_r[FRR_FRAME_ADDR_ERR] &&
						(ssw_r[FRR_SSW_STAGE_B_RERUN] | ssw_r[FRR_SSW_STAGE_C_RERUN] |
						ssw_r[FRR_SSW_DATA_FAULT])) begin
					st_nxt = FRR_ST_DEALLOC;
					exc_kind_nxt = FRR_EXC_ADDR;
				end else if (start_pulse) begin
					// need bits written together with start must count already
					st_nxt = frr_next(ssw_r, wr_merge, 2'h0);
				end
			end
			FRR_ST_DATA, FRR_ST_PF_C, FRR_ST_PF_B: begin
				if (cyc_bad) begin
					st_nxt = FRR_ST_DEALLOC;
					exc_kind_nxt = FRR_EXC_BUS;
				end else if (cyc_ok) begin
					st_nxt = frr_next(ssw_r, ctrl_r, (st_r == FRR_ST_DATA) ? 2'h1 :
						(st_r == FRR_ST_PF_C) ? 2'h2 : 2'h3);
				end
			end
			FRR_ST_LOCK: st_nxt = frr_next(ssw_r, ctrl_r, 2'h1);
			FRR_ST_DEALLOC: st_nxt = FRR_ST_BUILD;
			FRR_ST_BUILD: st_nxt = FRR_ST_EXC;
			FRR_ST_EXC, FRR_ST_DONE: st_nxt = FRR_ST_IDLE;
			default: st_nxt = FRR_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= FRR_ST_IDLE;
			exc_kind <= FRR_EXC_NONE;
		end else begin
			st_r <= st_nxt;
			exc_kind <= (st_r == FRR_ST_IDLE && !start_pulse) ? FRR_EXC_NONE : exc_kind_nxt;
		end
	end

	// the cycle to issue is loaded as the sequencer enters a bus state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_r <= 1'b0;
			cyc_r <= '0;
		end else begin
			req_r <= (st_nxt == FRR_ST_DATA || st_nxt == FRR_ST_PF_C || st_nxt == FRR_ST_PF_B) &&
				!(req_r && (cyc_ok || cyc_bad) && st_nxt == st_r) ? 1'b1 : 1'b0;
			if (st_nxt == FRR_ST_DATA) begin
				cyc_r.addr <= faddr_r;
				cyc_r.space <= ssw_r[FRR_SSW_SPACE_LO +: 3];
				cyc_r.size <= ssw_r[FRR_SSW_SIZE_LO +: 2];
				cyc_r.rd <= ssw_r[FRR_SSW_READ];
				cyc_r.read_modify_cycle_indicator <= 1'b0;
			end else if (st_nxt == FRR_ST_PF_C) begin
				cyc_r <= frr_pf(pfaddr_r, frame_r[FRR_FRAME_SUPER]);
			end else if (st_nxt == FRR_ST_PF_B) begin
				cyc_r <= frr_pf(pfaddr_r + FRR_STAGE_B_STEP, frame_r[FRR_FRAME_SUPER]);
			end
		end
	end

	// sequencing pulses toward the core
	assign locked_restart = (st_r == FRR_ST_LOCK);
	assign frame_dealloc = (st_r == FRR_ST_DEALLOC);
	assign frame_build = (st_r == FRR_ST_BUILD);
	assign exc_start = (st_r == FRR_ST_EXC);

	// captured read data: data buffer and the two stage images
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dib_r <= 32'h0000_0000;
			stage_r <= 32'h0000_0000;
		end else if (cyc_ok && st_r == FRR_ST_DATA && cyc_r.rd) begin
			dib_r <= bus_rdata;
		end else if (cyc_ok && st_r == FRR_ST_PF_C) begin
			stage_r[15:0] <= bus_rdata[15:0];
		end else if (cyc_ok && st_r == FRR_ST_PF_B) begin
			stage_r[31:16] <= bus_rdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// bus ownership and protection
	// ------------------------------------------------------------
	// reruns own the bus during a return; core cycles wait meanwhile
	assign mux_cyc = rerun_busy ? cyc_r : core_cyc;
	assign mux_valid = rerun_busy ? req_r : core_valid;

	frr_prot_chk u_prot (
		.cyc(mux_cyc),
		.cyc_valid(mux_valid),
		.wp_en(ctrl_r[FRR_CTRL_WP_EN]),
		.wp_page(ctrl_r[FRR_CTRL_WP_LO +: 4]),
		.is_write(pr_write),
		.violation(pr_viol)
	);

	// a violating cycle never reaches the pins; it ends at once as an error
	assign bus_cyc = mux_cyc;
	assign bus_valid = mux_valid & ~pr_viol;
	assign core_done = ~rerun_busy & core_valid & (pr_viol | bus_ack | bus_err);
	assign core_err = ~rerun_busy & core_valid & (pr_viol | bus_err);

	// ------------------------------------------------------------
	// interrupts and read path
	// ------------------------------------------------------------
	assign irq_set = {st_r == FRR_ST_EXC && exc_kind == FRR_EXC_ADDR,
		st_r == FRR_ST_EXC && exc_kind == FRR_EXC_BUS, st_r == FRR_ST_DONE};

	// set beats a write-one clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_stat_r <= {FRR_IRQ_W{1'b0}};
		end else if (wr_fire && aw_addr_r == FRR_OFF_IRQ_STAT) begin
			irq_stat_r <= (irq_stat_r & ~wr_merge[FRR_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	assign s_arready = ~s_rvalid;

	// status: busy, state, frame length in transfers (long words when aligned)
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= FRR_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= FRR_RESP_OKAY;
			unique case (s_araddr)
				FRR_OFF_CTRL: s_rdata <= ctrl_r;
				FRR_OFF_SSW: s_rdata <= {16'h0000, ssw_r};
				FRR_OFF_FADDR: s_rdata <= faddr_r;
				FRR_OFF_FRAME: s_rdata <= frame_r;
				FRR_OFF_PFADDR: s_rdata <= pfaddr_r;
				FRR_OFF_DIB: s_rdata <= dib_r;
				FRR_OFF_STATUS: s_rdata <= {17'h0_0000, (pfaddr_r[1:0] == 2'h0) ?
					{1'b0, frr_words(frame_r[FRR_FRAME_FMT_LO +: 4])} >> 1 :
					{1'b0, frr_words(frame_r[FRR_FRAME_FMT_LO +: 4])}, 3'h0, st_r, rerun_busy};
				FRR_OFF_IRQ_STAT: s_rdata <= {{(32-FRR_IRQ_W){1'b0}}, irq_stat_r};
				FRR_OFF_IRQ_MASK: s_rdata <= {{(32-FRR_IRQ_W){1'b0}}, irq_mask_r};
				FRR_OFF_STAGE: s_rdata <= stage_r;
				default: begin
					s_rdata <= 32'h0000_0000;
					s_rresp <= FRR_RESP_SLVERR;
				end
			endcase
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_addr_err_no_cycle;
		st_r == FRR_ST_IDLE && start_pulse && frame_r[FRR_FRAME_ADDR_ERR] |-> ##1 !req_r;
	endproperty
	a_addr_err_no_cycle: assert property (p_addr_err_no_cycle)
		else $error("address error frame started a rerun");
	property p_df_rerun;
		st_r == FRR_ST_IDLE && start_pulse && !frame_r[FRR_FRAME_ADDR_ERR] &&
			ssw_r[FRR_SSW_DATA_FAULT] && !ssw_r[FRR_SSW_LOCKED] |-> ##1 st_r == FRR_ST_DATA ##1 req_r;
	endproperty
	a_df_rerun: assert property (p_df_rerun)
		else $error("data fault not rerun");
	property p_pf_space;
		req_r && st_r == FRR_ST_PF_C |-> cyc_r.space ==
			(frame_r[FRR_FRAME_SUPER] ? FRR_SPACE_SUPER_PROG : FRR_SPACE_USER_PROG);
	endproperty
	a_pf_space: assert property (p_pf_space)
		else $error("prefetch in wrong space");
	property p_refault_seq;
		cyc_bad |=> frame_dealloc ##1 frame_build ##1 exc_start && exc_kind == FRR_EXC_BUS;
	endproperty
	a_refault_seq: assert property (p_refault_seq)
		else $error("refault sequence broken");
	property p_locked;
		st_r == FRR_ST_IDLE && start_pulse && !frame_r[FRR_FRAME_ADDR_ERR] &&
			ssw_r[FRR_SSW_DATA_FAULT] && ssw_r[FRR_SSW_LOCKED] |=> locked_restart && !req_r;
	endproperty
	a_locked: assert property (p_locked)
		else $error("locked operation not re-executed");
	property p_stage_mark;
		cyc_bad && st_r == FRR_ST_PF_B |=> ssw_r[FRR_SSW_STAGE_B_FAULT] && ssw_r[FRR_SSW_STAGE_B_RERUN];
	endproperty
	a_stage_mark: assert property (p_stage_mark)
		else $error("fault bit without rerun bit");
	property p_data_cycle;
		req_r && st_r == FRR_ST_DATA |-> cyc_r.addr == faddr_r &&
			cyc_r.size == ssw_r[FRR_SSW_SIZE_LO +: 2] && cyc_r.rd == ssw_r[FRR_SSW_READ];
	endproperty
	a_data_cycle: assert property (p_data_cycle)
		else $error("rerun data cycle differs from saved one");
	property p_nothing;
		st_r == FRR_ST_IDLE && start_pulse && ssw_r[15:12] == 4'h0 &&
			!ssw_r[FRR_SSW_DATA_FAULT] |=> st_r == FRR_ST_DONE ##1 !req_r;
	endproperty
	a_nothing: assert property (p_nothing)
		else $error("rerun cycle issued with nothing flagged");
	property p_rerun_only;
		st_r == FRR_ST_IDLE && start_pulse && !frame_r[FRR_FRAME_ADDR_ERR] &&
			ssw_r[15:12] == 4'h2 && !ssw_r[FRR_SSW_DATA_FAULT] && !wr_merge[FRR_CTRL_NEED_C]
			|=> st_r == FRR_ST_DONE;
	endproperty
	a_rerun_only: assert property (p_rerun_only)
		else $error("unneeded stage prefetched");
	property p_rmc_write;
		mux_valid && mux_cyc.read_modify_cycle_indicator |-> pr_write;
	endproperty
	a_rmc_write: assert property (p_rmc_write)
		else $error("locked cycle not classed as write");

	c_refault: cover property (cyc_bad ##3 exc_start);
	c_pf_b: cover property (cyc_ok && st_r == FRR_ST_PF_B);
	c_locked: cover property (locked_restart);
	c_refused: cover property (exc_start && exc_kind == FRR_EXC_ADDR);
endmodule

/* File: common/frr_pkg.sv */
// package for the fault-return rerun block: register map, field layout, carriers
// assumes a single 100 MHz clock domain and a 32-bit AXI4-Lite register port
package frr_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FRR_OFF_CTRL = 8'h00;
	localparam logic [7:0] FRR_OFF_SSW = 8'h04;
	localparam logic [7:0] FRR_OFF_FADDR = 8'h08;
	localparam logic [7:0] FRR_OFF_FRAME = 8'h0C;
	localparam logic [7:0] FRR_OFF_PFADDR = 8'h10;
	localparam logic [7:0] FRR_OFF_DIB = 8'h14;
	localparam logic [7:0] FRR_OFF_STATUS = 8'h18;
	localparam logic [7:0] FRR_OFF_IRQ_STAT = 8'h1C;
	localparam logic [7:0] FRR_OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] FRR_OFF_STAGE = 8'h24;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int FRR_CTRL_START = 0;
	localparam int FRR_CTRL_NEED_B = 1;
	localparam int FRR_CTRL_NEED_C = 2;
	localparam int FRR_CTRL_WP_EN = 3;
	localparam int FRR_CTRL_WP_LO = 4;
	localparam logic [31:0] FRR_CTRL_RST = 32'h0000_0000;

	// ------------------------------------------------------------
	// saved fault status word fields
	// ------------------------------------------------------------
	localparam int FRR_SSW_STAGE_C_FAULT = 15;
	localparam int FRR_SSW_STAGE_B_FAULT = 14;
	localparam int FRR_SSW_STAGE_C_RERUN = 13;
	localparam int FRR_SSW_STAGE_B_RERUN = 12;
	localparam int FRR_SSW_DATA_FAULT = 8;
	localparam int FRR_SSW_LOCKED = 7;
	localparam int FRR_SSW_READ = 6;
	localparam int FRR_SSW_SIZE_LO = 4;
	localparam int FRR_SSW_SPACE_LO = 0;
	localparam logic [15:0] FRR_SSW_RST = 16'h0000;

	// frame register: status register copy, format code, address-error marker
	localparam int FRR_FRAME_SUPER = 13;
	localparam int FRR_FRAME_FMT_LO = 16;
	localparam int FRR_FRAME_ADDR_ERR = 20;

	// program address spaces for user and supervisor prefetch
	localparam logic [2:0] FRR_SPACE_USER_PROG = 3'h2;
	localparam logic [2:0] FRR_SPACE_SUPER_PROG = 3'h6;
	localparam logic [1:0] FRR_SIZE_WORD = 2'h2;
	localparam logic [31:0] FRR_STAGE_B_STEP = 32'h0000_0002;

	// interrupt status bits
	localparam int FRR_IRQ_DONE = 0;
	localparam int FRR_IRQ_REFAULT = 1;
	localparam int FRR_IRQ_REFUSED = 2;
	localparam int FRR_IRQ_W = 3;

	// ------------------------------------------------------------
	// exception stack frame formats and their size in 16-bit words
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		FRR_FMT_NORMAL4 = 4'h0,
		FRR_FMT_THROW4 = 4'h1,
		FRR_FMT_NORMAL6 = 4'h2,
		FRR_FMT_COPROC = 4'h9,
		FRR_FMT_SHORT_BUS = 4'hA,
		FRR_FMT_LONG_BUS = 4'hB
	} frr_fmt_t;
	localparam logic [5:0] FRR_WORDS_4 = 6'h04;
	localparam logic [5:0] FRR_WORDS_6 = 6'h06;
	localparam logic [5:0] FRR_WORDS_COPROC = 6'h0A;
	localparam logic [5:0] FRR_WORDS_SHORT = 6'h10;
	localparam logic [5:0] FRR_WORDS_LONG = 6'h2E;

	// exception kind raised after a rerun faults or an address-error frame is refused
	typedef enum logic [1:0] {
		FRR_EXC_NONE = 2'h0,
		FRR_EXC_BUS = 2'h1,
		FRR_EXC_ADDR = 2'h2
	} frr_exc_t;

	// one processor bus cycle
	typedef struct packed {
		logic [31:0] addr;
		logic [2:0] space;
		logic [1:0] size;
		logic rd;
		logic read_modify_cycle_indicator;
	} frr_cyc_t;

	// AXI response codes
	localparam logic [1:0] FRR_RESP_OKAY = 2'h0;
	localparam logic [1:0] FRR_RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/frr_prot_chk.sv */
// protection classifier for every cycle that leaves the block
// assumes the write-protected region is one 256 MB page selected by software
module frr_prot_chk (
	// cycle under test
	input wire frr_pkg::frr_cyc_t cyc,
	input wire logic cyc_valid,
	// protection setup
	input wire logic wp_en,
	input wire logic [3:0] wp_page,
	// verdict
	output logic is_write,
	output logic violation
);
	import frr_pkg::*;

	// ------------------------------------------------------------
	// classification
	// ------------------------------------------------------------
	// a locked cycle counts as a write even when it reads, so a half-done
	// compare-and-swap cannot slip past protection on its read
	always_comb begin
		is_write = cyc.read_modify_cycle_indicator | ~cyc.rd;
		violation = cyc_valid & wp_en & is_write & (cyc.addr[31:28] == wp_page);
	end
endmodule

/* File: verification/frr_bus_model.sv */
// processor bus responder standing for memory and peripherals
// assumes one clock; answers each held cycle once, with error when told to
module frr_bus_model (
	// bus side
	input wire logic ref_clk,
	input wire logic rst,
	input wire frr_pkg::frr_cyc_t bus_cyc,
	input wire logic bus_valid,
	// scenario control
	input wire logic err_en,
	// answer
	output logic bus_ack,
	output logic bus_err,
	output logic [31:0] bus_rdata
);
	import frr_pkg::*;
	logic [1:0] wait_r;
	// address bit 13 picks a slow answer; data is scrambled outside an answer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_r <= 2'h0;
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
			bus_rdata <= 32'h0;
		end else if (bus_valid && !bus_ack && !bus_err && wait_r >= {bus_cyc.addr[13], 1'b0}) begin
			wait_r <= 2'h0;
			bus_ack <= !err_en;
			bus_err <= err_en;
			bus_rdata <= ~bus_cyc.addr;
		end else begin
			wait_r <= bus_valid && !bus_ack && !bus_err ? wait_r + 2'h1 : 2'h0;
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
			bus_rdata <= ~bus_rdata;
		end
	end
endmodule

/* File: verification/tb_frr_top.sv */
// self-checking bench for the fault-return rerun unit
// assumes the partner model on the bus and a 100 MHz clock
module tb_frr_top;
	timeunit 1ns;
	timeprecision 1ps;
	import frr_pkg::*;
	logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, core_valid = 0, core_done, core_err;
	logic bus_valid, bus_ack, bus_err, lrs, fdl, fbd, exs, irq, err_en = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, bus_rdata, rv;
	logic [1:0] bresp, rresp;
	frr_exc_t exc_kind, kind_seen;
	frr_cyc_t core_cyc = '0, bus_cyc, last;
	int errors = 0, total_checks = 0, n_bus, n_lr, n_fr, n_ex, cyc_n = 0;
	localparam logic [15:0] SAVED_FAULT_STATUS_WORD [6] = '{16'h0000, 16'h0155, 16'h0055, 16'hA000, 16'h2000, 16'h1000};
	localparam logic [31:0] FRM [6] = '{32'hB0000, 32'hB0000, 32'hB0000, 32'hB2000, 32'hB0000, 32'hB0000};
	localparam logic [31:0] CTL [6] = '{0, 0, 0, 0, 0, 32'h2};
	localparam int NCY [6] = '{0, 1, 0, 1, 0, 1};
	localparam frr_cyc_t EXP [6] = '{'0, '{32'h2000, 3'h5, 2'h1, 1'b1, 1'b0}, '0,
		'{32'h1000, FRR_SPACE_SUPER_PROG, FRR_SIZE_WORD, 1'b1, 1'b0}, '0,
		'{32'h1002, FRR_SPACE_USER_PROG, FRR_SIZE_WORD, 1'b1, 1'b0}};
	always #5 ref_clk = ~ref_clk;
	frr_top u_frr_top (.ref_clk(ref_clk), .rst(rst), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
		.s_rvalid(rvalid), .s_rready(rready), .core_cyc(core_cyc), .core_valid(core_valid),
		.core_done(core_done), .core_err(core_err), .bus_cyc(bus_cyc), .bus_valid(bus_valid),
		.bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .locked_restart(lrs),
		.frame_dealloc(fdl), .frame_build(fbd), .exc_start(exs), .exc_kind(exc_kind), .irq(irq));
	frr_bus_model u_frr_bus_model (.ref_clk(ref_clk), .rst(rst), .bus_cyc(bus_cyc),
		.bus_valid(bus_valid), .err_en(err_en), .bus_ack(bus_ack), .bus_err(bus_err),
		.bus_rdata(bus_rdata));
	// count finished bus cycles and core sequencing pulses; also the hang limit
	always @(posedge ref_clk) begin
		if (bus_valid && (bus_ack || bus_err)) begin
			n_bus++;
			last = bus_cyc;
		end
		n_lr += lrs;
		n_fr += fdl + fbd;
		n_ex += exs;
		if (exs) kind_seen = exc_kind;
		if (++cyc_n == 20000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one write; each channel is released at the edge where it was taken
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rready <= 0;
	endtask
	// load a frame image, start the return, wait for the interrupt, clear it
	task automatic run(logic [15:0] s, logic [31:0] f, logic [31:0] c, logic [31:0] st);
		n_bus = 0;
		n_lr = 0;
		n_fr = 0;
		n_ex = 0;
		kind_seen = FRR_EXC_NONE;
		wr(FRR_OFF_SSW, {16'h0, s});
		wr(FRR_OFF_FADDR, 32'h2000);
		wr(FRR_OFF_FRAME, f);
		wr(FRR_OFF_PFADDR, 32'h1000);
		wr(FRR_OFF_CTRL, c | 32'h1);
		repeat (200) if (irq !== 1'b1) @(posedge ref_clk);
		rd(FRR_OFF_IRQ_STAT);
		chk("irq_stat", rv, st);
		wr(FRR_OFF_IRQ_STAT, rv);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		wr(FRR_OFF_IRQ_MASK, 32'h7);
		for (int i = 0; i < 6; i++) begin
			run(SAVED_FAULT_STATUS_WORD[i], FRM[i], CTL[i], 32'h1);
			chk("cycles", n_bus, NCY[i]);
			if (NCY[i] > 0) chk("cycle_addr", last.addr, EXP[i].addr);
			if (NCY[i] > 0) chk("cycle_kind", 32'(last[6:0]), 32'(EXP[i][6:0]));
		end
		run(16'h0180, 32'hB0000, 0, 32'h1);
		chk("locked", n_lr, 1);
		chk("locked_cycles", n_bus, 0);
		err_en <= 1;
		run(16'h0155, 32'hB0000, 0, 32'h2);
		chk("refault_frame", n_fr, 2);
		chk("refault_exc", n_ex, 1);
		chk("refault_kind", 32'(kind_seen), 32'(FRR_EXC_BUS));
		// a needed stage B prefetch that faults must mark fault and rerun
		run(16'h1000, 32'hB0000, 32'h2, 32'h2);
		rd(FRR_OFF_SSW);
		chk("ssw_mark", rv, 32'h0000_5000);
		chk("refault_b", n_fr, 2);
		err_en <= 0;
		run(16'h3000, 32'h1B0000, 0, 32'h4);
		chk("addr_err_cycles", n_bus, 0);
		chk("addr_err_kind", 32'(kind_seen), 32'(FRR_EXC_ADDR));
		wr(FRR_OFF_CTRL, 32'h38);
		n_bus = 0;
		core_cyc <= '{32'h3000_0000, 3'h5, 2'h0, 1'b1, 1'b1};
		core_valid <= 1;
		repeat (50) if (core_done !== 1'b1) @(posedge ref_clk);
		chk("rmc_wp", {core_err, n_bus[0]}, 2);
		core_valid <= 0;
		// reset while an address-error frame with data fault is being refused must leave the unit idle
		wr(FRR_OFF_SSW, 32'h0000_0155);
		wr(FRR_OFF_CTRL, 32'h0000_0001);
		@(posedge ref_clk);
		rst <= 1;
		@(posedge ref_clk);
		rst <= 0;
		chk("rst_bus_valid", 32'(bus_valid), 32'h0);
		rd(FRR_OFF_SSW);
		chk("rst_ssw", rv, 32'(FRR_SSW_RST));
		rd(8'h30);
		chk("unmapped", rresp, FRR_RESP_SLVERR);
		wrap_up();
	end
endmodule
